// ---- logic/cmpev_cfg.svh ----
`ifndef CMPEV_CFG_SVH
`define CMPEV_CFG_SVH
// Contract
// - result high only when positive exceeds negative
// - two comparators, same logic, separate settings
// - either input selectable from a port pin; positive reaches pins 0 to 6 only, negative pins 0, 1, 3, 5 and 7 only
// - internal sources: dac, bandgap, 64-level scaler
// - enabled result updates continuously, readable, first one exported
// - interrupt on toggle, rising or falling edge
// - event on selected edge, interrupt enabled or not
// - window mode classifies signal against range
// - window events above, inside or below range
// - hysteresis none, small or large to front end
// - low power default, fast mode selectable
// - first comparator result optionally driven onto a port pin
// - current source enable and pin selection
// - edge codes toggle 00, fall 10, rise 11
// - window codes above 00, inside 01, below 10, outside 11
// - hysteresis codes none 00, small 01, large 10
// - window mode only while window enable set

// register indices; byte address is four times the index
`define CMPEV_IDX_CTRL0 3'h0
`define CMPEV_IDX_CTRL1 3'h1
`define CMPEV_IDX_MUX0 3'h2
`define CMPEV_IDX_MUX1 3'h3
`define CMPEV_IDX_PINCTL 3'h4
`define CMPEV_IDX_SCALE 3'h5
`define CMPEV_IDX_WIN 3'h6
`define CMPEV_IDX_STATUS 3'h7
// address field positions
`define CMPEV_ADDR_IDX_HI 4
`define CMPEV_ADDR_IDX_LO 2
`define CMPEV_ADDR_MAP_LO 5
`define CMPEV_ADDR_UPPER_ZERO 27'h0000000
`define CMPEV_ADDR_ALIGN_ZERO 2'h0
// reset values
`define CMPEV_RST_BYTE 8'h00
`define CMPEV_RST_WORD 32'h00000000
// edge condition codes
`define CMPEV_EDGE_TOGGLE 2'h0
`define CMPEV_EDGE_RSVD 2'h1
`define CMPEV_EDGE_FALL 2'h2
`define CMPEV_EDGE_RISE 2'h3
// window condition codes
`define CMPEV_WIN_ABOVE 2'h0
`define CMPEV_WIN_INSIDE 2'h1
`define CMPEV_WIN_BELOW 2'h2
`define CMPEV_WIN_OUTSIDE 2'h3
// hysteresis codes
`define CMPEV_HYS_NONE 2'h0
`define CMPEV_HYS_SMALL 2'h1
`define CMPEV_HYS_LARGE 2'h2
`define CMPEV_HYS_RSVD 2'h3
// internal source codes of the input selectors
`define CMPEV_POS_DAC 3'h7
`define CMPEV_NEG_DAC 3'h5
`define CMPEV_NEG_BANDGAP 3'h6
`define CMPEV_NEG_SCALER 3'h7
// interrupt level meaning disabled
`define CMPEV_LVL_OFF 2'h0
`endif

// ---- logic/cmpev_pkg.sv ----
package cmpev_pkg;
	// per-comparator control byte, msb first
	typedef struct packed {
		logic [1:0] edgeSel;
		logic [1:0] irqLevel;
		logic fastSel;
		logic [1:0] hysSel;
		logic enable;
	} cmpev_ctrl_t;
	// input selectors of one comparator
	typedef struct packed {
		logic [2:0] posSel;
		logic [2:0] negSel;
	} cmpev_mux_t;
	// pin output and current source control
	typedef struct packed {
		logic [2:0] curPin;
		logic curEnable;
		logic resultOut;
	} cmpev_pin_t;
	// window control
	typedef struct packed {
		logic winEnable;
		logic [1:0] winSel;
		logic [1:0] irqLevel;
	} cmpev_win_t;
	// window state as reported in status
	typedef enum logic [1:0] {
		CMPEV_WS_ABOVE = 2'b00,
		CMPEV_WS_INSIDE = 2'b01,
		CMPEV_WS_BELOW = 2'b10
	} cmpev_winstate_t;
	// settings handed to one analog front end
	typedef struct packed {
		logic enable;
		logic fastSel;
		logic [1:0] hysSel;
		logic [2:0] posSel;
		logic [2:0] negSel;
	} cmpev_afe_t;
	// ahb-lite request side
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} cmpev_ahb_req_t;
	// ahb-lite response side
	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
	} cmpev_ahb_rsp_t;
	// state of one edge detector
	typedef struct packed {
		logic meta;
		logic sync;
		logic level;
		logic prev;
		logic [1:0] armed;
	} cmpev_edge_st_t;
	// state of the top module
	typedef struct packed {
		cmpev_ctrl_t [1:0] ctrl;
		cmpev_mux_t [1:0] mux;
		cmpev_pin_t pin;
		logic [5:0] scale;
		cmpev_win_t win;
		logic [2:0] flags;
		cmpev_winstate_t winState;
		logic winArmed;
		logic [2:0] events;
		logic [2:0] irq;
		logic pinOut;
		logic pinEnN;
		logic dWr;
		logic [2:0] dIdx;
		logic [31:0] hrdata;
		logic hready;
	} cmpev_state_t;
endpackage : cmpev_pkg

// ---- logic/cmpev_edge.sv ----
`include "cmpev_cfg.svh"
module cmpev_edge (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// comparator decision from the analog side
	input wire logic rawResult,
	// settings on the same clock
	input wire logic enable,
	input wire logic [1:0] edgeSel,
	// synchronised result and edge strobe
	output logic result,
	output logic edgeHit
);
	cmpev_pkg::cmpev_edge_st_t s_r;
	cmpev_pkg::cmpev_edge_st_t s_nxt;
	logic rise;
	logic fall;

	// synchroniser, gated level, previous sample and arming delay
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = rawResult;
		s_nxt.sync = s_r.meta;
		s_nxt.level = enable & s_r.sync;
		s_nxt.prev = s_r.level;
		s_nxt.armed = {s_r.armed[0] & enable, enable};
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// classify the change between two samples
	assign rise = s_r.level & ~s_r.prev;
	assign fall = ~s_r.level & s_r.prev;

	// first sample after enabling is not taken as an edge
	always_comb begin
		edgeHit = 1'b0;
		if (enable && s_r.armed[1]) begin
			case (edgeSel)
				`CMPEV_EDGE_TOGGLE: edgeHit = rise | fall;
				`CMPEV_EDGE_FALL: edgeHit = fall;
				`CMPEV_EDGE_RISE: edgeHit = rise;
				default: edgeHit = 1'b0;
			endcase
		end
	end

	assign result = s_r.level;

	chk_disabled_low: assert property (@(posedge mclk) disable iff (!resetn)
		!enable |=> !result)
		else $error("result high while comparator disabled");
	chk_rise_only: assert property (@(posedge mclk) disable iff (!resetn)
		(edgeHit && edgeSel == `CMPEV_EDGE_RISE) |-> (result && !s_r.prev))
		else $error("rising strobe without rising edge");
	chk_toggle_seen: assert property (@(posedge mclk) disable iff (!resetn)
		(enable && s_r.armed[1] && edgeSel == `CMPEV_EDGE_TOGGLE && result != s_r.prev)
		|-> edgeHit)
		else $error("toggle missed");
	chk_rsvd_quiet: assert property (@(posedge mclk) disable iff (!resetn)
		edgeSel == `CMPEV_EDGE_RSVD |-> !edgeHit)
		else $error("strobe on reserved edge code");
endmodule : cmpev_edge

// ---- logic/cmpev_top.sv ----
`include "cmpev_cfg.svh"
module cmpev_top (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// register bus
	input wire cmpev_pkg::cmpev_ahb_req_t ahbReq,
	output cmpev_pkg::cmpev_ahb_rsp_t ahbRsp,
	// analog comparator decisions, one per unit
	input wire logic [1:0] cmpRaw,
	// analog front-end settings
	output cmpev_pkg::cmpev_afe_t [1:0] afeCtrl,
	output logic [5:0] scaleFactor,
	output logic currentEnable,
	output logic [2:0] currentPin,
	// result pin of the first comparator
	output logic resultPin,
	output logic resultPinEnN,
	// event strobes and interrupt requests
	output logic [1:0] cmpEvent,
	output logic winEvent,
	output logic [2:0] irqReq
);
	cmpev_pkg::cmpev_state_t s_r;
	cmpev_pkg::cmpev_state_t s_nxt;
	logic [1:0] cmpResult;
	logic [1:0] edgeHit;
	logic [2:0] hits;
	logic [2:0] clearMask;
	logic [7:0] wByte;
	logic [7:0] rdByte;
	logic accept;
	logic mapped;
	logic [2:0] aIdx;
	logic winHit;
	cmpev_pkg::cmpev_winstate_t winCur;

	// word index of a bus address
	function automatic logic [2:0] regIndex(input logic [31:0] addr);
		regIndex = addr[`CMPEV_ADDR_IDX_HI:`CMPEV_ADDR_IDX_LO];
	endfunction : regIndex

	// address lies on a register word
	function automatic logic isMapped(input logic [31:0] addr);
		isMapped = (addr[31:`CMPEV_ADDR_MAP_LO] == `CMPEV_ADDR_UPPER_ZERO)
			&& (addr[`CMPEV_ADDR_IDX_LO-1:0] == `CMPEV_ADDR_ALIGN_ZERO);
	endfunction : isMapped

	// an interrupt level other than zero enables the request
	function automatic logic levelOn(input logic [1:0] lvl);
		levelOn = (lvl != `CMPEV_LVL_OFF);
	endfunction : levelOn

	// read view of one register, reserved bits as zero
	function automatic logic [7:0] readReg(
		input cmpev_pkg::cmpev_state_t st,
		input logic [2:0] idx,
		input logic [1:0] res
	);
		readReg = `CMPEV_RST_BYTE;
		if (idx == `CMPEV_IDX_CTRL0) begin
			readReg = st.ctrl[0];
		end else if (idx == `CMPEV_IDX_CTRL1) begin
			readReg = st.ctrl[1];
		end else if (idx == `CMPEV_IDX_MUX0) begin
			readReg = {2'h0, st.mux[0]};
		end else if (idx == `CMPEV_IDX_MUX1) begin
			readReg = {2'h0, st.mux[1]};
		end else if (idx == `CMPEV_IDX_PINCTL) begin
			readReg = {3'h0, st.pin};
		end else if (idx == `CMPEV_IDX_SCALE) begin
			readReg = {2'h0, st.scale};
		end else if (idx == `CMPEV_IDX_WIN) begin
			readReg = {3'h0, st.win};
		end else begin
			readReg = {st.winState, res[1], res[0], 1'b0, st.flags};
		end
	endfunction : readReg

	// the pair of identical comparator channels
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gCmp
			cmpev_edge uEdge (
				.mclk(mclk),
				.resetn(resetn),
				.rawResult(cmpRaw[gi]),
				.enable(s_r.ctrl[gi].enable),
				.edgeSel(s_r.ctrl[gi].edgeSel),
				.result(cmpResult[gi]),
				.edgeHit(edgeHit[gi])
			);
		end
	endgenerate

	// window state: first unit holds the upper bound, second the lower
	always_comb begin
		if (cmpResult[0]) begin
			winCur = cmpev_pkg::CMPEV_WS_ABOVE;
		end else if (cmpResult[1]) begin
			winCur = cmpev_pkg::CMPEV_WS_INSIDE;
		end else begin
			winCur = cmpev_pkg::CMPEV_WS_BELOW;
		end
	end

	// window trigger on entry into the selected region
	always_comb begin
		winHit = 1'b0;
		if (s_r.win.winEnable && s_r.winArmed && winCur != s_r.winState) begin
			case (s_r.win.winSel)
				`CMPEV_WIN_ABOVE: winHit = (winCur == cmpev_pkg::CMPEV_WS_ABOVE);
				`CMPEV_WIN_INSIDE: winHit = (winCur == cmpev_pkg::CMPEV_WS_INSIDE);
				`CMPEV_WIN_BELOW: winHit = (winCur == cmpev_pkg::CMPEV_WS_BELOW);
				default: winHit = (s_r.winState == cmpev_pkg::CMPEV_WS_INSIDE);
			endcase
		end
	end

	// bus decode of the address phase
	assign accept = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready;
	assign mapped = isMapped(ahbReq.haddr);
	assign aIdx = regIndex(ahbReq.haddr);
	assign wByte = ahbReq.hwdata[7:0];
	assign hits = {winHit, edgeHit};

	// next state: writes, flags, events, window tracking, bus answer
	always_comb begin
		s_nxt = s_r;
		clearMask = 3'h0;
		// commit the write whose data phase is now on the bus
		if (s_r.dWr) begin
			if (s_r.dIdx == `CMPEV_IDX_CTRL0) begin
				s_nxt.ctrl[0] = cmpev_pkg::cmpev_ctrl_t'(wByte);
			end else if (s_r.dIdx == `CMPEV_IDX_CTRL1) begin
				s_nxt.ctrl[1] = cmpev_pkg::cmpev_ctrl_t'(wByte);
			end else if (s_r.dIdx == `CMPEV_IDX_MUX0) begin
				s_nxt.mux[0] = cmpev_pkg::cmpev_mux_t'(wByte[5:0]);
			end else if (s_r.dIdx == `CMPEV_IDX_MUX1) begin
				s_nxt.mux[1] = cmpev_pkg::cmpev_mux_t'(wByte[5:0]);
			end else if (s_r.dIdx == `CMPEV_IDX_PINCTL) begin
				s_nxt.pin = cmpev_pkg::cmpev_pin_t'(wByte[4:0]);
			end else if (s_r.dIdx == `CMPEV_IDX_SCALE) begin
				s_nxt.scale = wByte[5:0];
			end else if (s_r.dIdx == `CMPEV_IDX_WIN) begin
				s_nxt.win = cmpev_pkg::cmpev_win_t'(wByte[4:0]);
			end else begin
				clearMask = wByte[2:0];
			end
		end
		// sticky flags: a new hit beats a clear in the same cycle
		s_nxt.flags = (s_r.flags & ~clearMask) | hits;
		// event strobes go out whatever the interrupt level
		s_nxt.events = hits;
		s_nxt.irq[0] = s_nxt.flags[0] & levelOn(s_nxt.ctrl[0].irqLevel);
		s_nxt.irq[1] = s_nxt.flags[1] & levelOn(s_nxt.ctrl[1].irqLevel);
		s_nxt.irq[2] = s_nxt.flags[2] & levelOn(s_nxt.win.irqLevel);
		// window state is followed every clock, armed one cycle after enable
		s_nxt.winState = winCur;
		s_nxt.winArmed = s_r.win.winEnable;
		// first comparator result onto its pin
		s_nxt.pinOut = s_nxt.pin.resultOut & cmpResult[0];
		s_nxt.pinEnN = ~s_nxt.pin.resultOut;
		// capture the address phase; reads see writes already committed
		s_nxt.dWr = accept & ahbReq.hwrite & mapped;
		s_nxt.dIdx = aIdx;
		rdByte = readReg(s_nxt, aIdx, cmpResult);
		if (accept && !ahbReq.hwrite) begin
			s_nxt.hrdata = mapped ? {24'h000000, rdByte} : `CMPEV_RST_WORD;
		end
		s_nxt.hready = 1'b1;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.hready <= 1'b1;
			s_r.pinEnN <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign ahbRsp.hreadyout = s_r.hready;
	assign ahbRsp.hresp = 1'b0;
	assign ahbRsp.hrdata = s_r.hrdata;
	assign scaleFactor = s_r.scale;
	assign currentEnable = s_r.pin.curEnable;
	assign currentPin = s_r.pin.curPin;
	assign resultPin = s_r.pinOut;
	assign resultPinEnN = s_r.pinEnN;
	assign cmpEvent = s_r.events[1:0];
	assign winEvent = s_r.events[2];
	assign irqReq = s_r.irq;

	// front-end settings per unit
	generate
		for (gi = 0; gi < 2; gi++) begin : gAfe
			assign afeCtrl[gi].enable = s_r.ctrl[gi].enable;
			assign afeCtrl[gi].fastSel = s_r.ctrl[gi].fastSel;
			assign afeCtrl[gi].hysSel = s_r.ctrl[gi].hysSel;
			assign afeCtrl[gi].posSel = s_r.mux[gi].posSel;
			assign afeCtrl[gi].negSel = s_r.mux[gi].negSel;
		end
	endgenerate

	// window entry into inside: two samples of state and then the strobe
	sequence seqInsideArmed;
		s_r.win.winEnable && s_r.winArmed && s_r.win.winSel == `CMPEV_WIN_INSIDE;
	endsequence
	sequence seqEnterInside;
		seqInsideArmed and (winCur == cmpev_pkg::CMPEV_WS_INSIDE
			&& s_r.winState != cmpev_pkg::CMPEV_WS_INSIDE);
	endsequence
	property propInsideEvent;
		@(posedge mclk) disable iff (!resetn)
		seqEnterInside |=> winEvent && s_r.flags[2];
	endproperty
	chk_win_inside: assert property (propInsideEvent)
		else $error("no window event on entry inside");

	chk_win_off: assert property (@(posedge mclk) disable iff (!resetn)
		!s_r.win.winEnable |=> !winEvent)
		else $error("window event while window disabled");

	chk_flag_set_wins: assert property (@(posedge mclk) disable iff (!resetn)
		edgeHit[0] |=> s_r.flags[0] && cmpEvent[0])
		else $error("edge hit lost or flag cleared over it");

	chk_irq_gate: assert property (@(posedge mclk) disable iff (!resetn)
		(edgeHit[1] && levelOn(s_nxt.ctrl[1].irqLevel)) |=> irqReq[1])
		else $error("interrupt request missing");

	chk_irq_quiet: assert property (@(posedge mclk) disable iff (!resetn)
		(s_r.ctrl[0].irqLevel == `CMPEV_LVL_OFF) |-> !irqReq[0])
		else $error("interrupt request with level off");

	chk_pin_drive: assert property (@(posedge mclk) disable iff (!resetn)
		(s_r.pin.resultOut && cmpResult[0]) |=> (resultPin || !$past(s_nxt.pin.resultOut)))
		else $error("result pin not driven");

	chk_win_state: assert property (@(posedge mclk) disable iff (!resetn)
		(cmpResult[0] ##1 1'b1) |-> s_r.winState == cmpev_pkg::CMPEV_WS_ABOVE)
		else $error("window state not above");

	chk_bus_ready: assert property (@(posedge mclk) disable iff (!resetn)
		ahbRsp.hreadyout && !ahbRsp.hresp)
		else $error("slave not ready or error response");

	chk_read_unmapped: assert property (@(posedge mclk) disable iff (!resetn)
		(accept && !ahbReq.hwrite && !mapped) |=> ahbRsp.hrdata == `CMPEV_RST_WORD)
		else $error("unmapped read not zero");
endmodule : cmpev_top

// ---- dv/cmpev_analog_model.sv ----
module cmpev_analog_model (
	// front-end settings from the block
	input wire cmpev_pkg::cmpev_afe_t [1:0] afeCtrl,
	input wire logic [5:0] scaleFactor,
	// pin and reference voltages in millivolts
	input var int pinMv [8],
	input var int dacMv,
	input var int gapMv,
	// comparator decisions
	output logic [1:0] cmpRaw
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int VccMv = 3300;
	localparam int NegPin [5] = '{0, 1, 3, 5, 7};
	int posMv [2];
	int negMv [2];
	// input selection and voltage comparison of each unit
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			posMv[u] = (afeCtrl[u].posSel == 3'h7) ? dacMv : pinMv[afeCtrl[u].posSel];
			if (afeCtrl[u].negSel < 3'h5) begin
				negMv[u] = pinMv[NegPin[afeCtrl[u].negSel]];
			end else if (afeCtrl[u].negSel == 3'h5) begin
				negMv[u] = dacMv;
			end else if (afeCtrl[u].negSel == 3'h6) begin
				negMv[u] = gapMv;
			end else begin
				negMv[u] = VccMv * (int'(scaleFactor) + 1) / 64;
			end
			// a disabled unit gives a low decision
			cmpRaw[u] = afeCtrl[u].enable && (posMv[u] > negMv[u]);
		end
	end
endmodule : cmpev_analog_model

// ---- dv/cmpev_top_test.sv ----
module cmpev_top_test;
	timeunit 1ns;
	timeprecision 1ps;
`define CHECK(g, e) begin nCompared++; if ((g) !== (e)) begin numErrors++; \
	$display("wrong value at %0t: %0h vs %0h", $time, (g), (e)); end end
	// clock, reset and bus
	logic mclk;
	logic resetn;
	cmpev_pkg::cmpev_ahb_req_t busReq;
	cmpev_pkg::cmpev_ahb_req_t ahbReq;
	cmpev_pkg::cmpev_ahb_rsp_t ahbRsp;
	// analog side and block outputs
	logic [1:0] cmpRaw;
	cmpev_pkg::cmpev_afe_t [1:0] afeCtrl;
	logic [5:0] scaleFactor;
	logic currentEnable;
	logic [2:0] currentPin;
	logic resultPin;
	logic resultPinEnN;
	logic [1:0] cmpEvent;
	logic winEvent;
	logic [2:0] irqReq;
	int pinMv [8];
	int numErrors;
	int nCompared;
	int nEdge;
	int nEdge1;
	int nWin;
	logic [31:0] rd;

	cmpev_top u_cmpev_top (.mclk(mclk), .resetn(resetn), .ahbReq(ahbReq), .ahbRsp(ahbRsp),
		.cmpRaw(cmpRaw), .afeCtrl(afeCtrl), .scaleFactor(scaleFactor),
		.currentEnable(currentEnable), .currentPin(currentPin), .resultPin(resultPin),
		.resultPinEnN(resultPinEnN), .cmpEvent(cmpEvent), .winEvent(winEvent), .irqReq(irqReq));
	cmpev_analog_model u_cmpev_analog_model (.afeCtrl(afeCtrl), .scaleFactor(scaleFactor),
		.pinMv(pinMv), .dacMv(0), .gapMv(1100), .cmpRaw(cmpRaw));

	// the single slave drives the bus hready
	always_comb begin
		ahbReq = busReq;
		ahbReq.hready = ahbRsp.hreadyout;
	end
	// clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// event pulse counters, sampled before the edge updates land
	always @(posedge mclk) begin
		if (cmpEvent[0] === 1'b1) nEdge++;
		if (winEvent === 1'b1) nWin++;
		if (cmpEvent[1] === 1'b1) nEdge1++;
	end
	// watchdog against a hung bus or scenario
	initial begin
		#200us;
		numErrors++;
		finish_test();
	end

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	// waits as long as the slave stalls; only the watchdog ends a hung wait
	task automatic wait_ready;
		do begin
			@(posedge mclk);
		end while (ahbRsp.hreadyout !== 1'b1);
	endtask : wait_ready

	// one single word transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		busReq.hsel <= 1'b1;
		busReq.htrans <= 2'h2;
		busReq.haddr <= a;
		busReq.hwrite <= wr;
		busReq.hsize <= 3'h2;
		wait_ready();
		busReq.hsel <= 1'b0;
		busReq.htrans <= 2'h0;
		busReq.hwdata <= d;
		wait_ready();
		r = ahbRsp.hrdata;
	endtask : bus

	// write, then one idle cycle so the outputs have settled
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, {27'h0, i, 2'h0}, {24'h0, d}, r);
		@(posedge mclk);
	endtask : wr

	task automatic rdv(input logic [2:0] i);
		bus(1'b0, {27'h0, i, 2'h0}, 32'h0, rd);
	endtask : rdv

	task automatic settle;
		repeat (8) @(posedge mclk);
	endtask : settle

	task automatic t_reset;
		`CHECK({ahbRsp.hreadyout, ahbRsp.hresp, resultPinEnN, afeCtrl}, {3'h5, 20'h0})
		// both units off read low, so the window state already shows below
		for (int i = 0; i < 8; i++) begin
			rdv(i[2:0]);
			`CHECK(rd, (i == 7) ? 32'h80 : 32'h0)
		end
		bus(1'b0, 32'h20, 32'h0, rd);
		`CHECK(rd, 32'h0)
		// an unmapped write aliasing index 0 must leave the first control alone
		bus(1'b1, 32'h20, 32'hFF, rd);
		rdv(3'h0);
		`CHECK(rd, 32'h0)
	endtask : t_reset

	task automatic t_settings;
		for (int h = 0; h < 4; h++) begin
			wr(3'h0, {4'h0, 1'b1, h[1:0], 1'b0});
			`CHECK(afeCtrl[0].hysSel, h[1:0])
			`CHECK(afeCtrl[0].fastSel, 1'b1)
		end
		wr(3'h1, 8'h08);
		`CHECK({afeCtrl[0].fastSel, afeCtrl[1]}, 11'h500)
		wr(3'h3, 8'hEE);
		rdv(3'h3);
		`CHECK(rd, 32'h2E)
		`CHECK(afeCtrl[1].posSel, 3'h5)
		wr(3'h5, 8'h3F);
		`CHECK(scaleFactor, 6'h3F)
		wr(3'h4, 8'h1F);
		`CHECK({currentEnable, currentPin, resultPinEnN}, 5'h1E)
	endtask : t_settings

	// every edge code, last one with its interrupt level off
	task automatic t_edges;
		int exp [4] = '{2, 0, 1, 1};
		logic [1:0] c;
		wr(3'h2, 8'h01);
		pinMv[1] <= 1000;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(3'h0, {c, (c == 2'h3) ? 2'h0 : 2'h1, 4'h1});
			pinMv[0] <= 0;
			settle();
			wr(3'h7, 8'h07);
			nEdge = 0;
			pinMv[0] <= 2000;
			settle();
			rdv(3'h7);
			`CHECK(rd[4], 1'b1)
			`CHECK(resultPin, 1'b1)
			pinMv[0] <= 0;
			settle();
			`CHECK(nEdge, exp[i])
			`CHECK(irqReq[0], ~c[0])
			rdv(3'h7);
			`CHECK(rd[0], c != 2'h1)
		end
		wr(3'h7, 8'h07);
		`CHECK(irqReq, 3'h0)
	endtask : t_edges

	// window bounds 2000 and 1000, signal walks a fixed path
	task automatic t_window;
		int path [8] = '{2500, 500, 2500, 500, 2500, 500, 1500, 500};
		int exp [5] = '{3, 1, 4, 2, 0};
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h12);
		wr(3'h3, 8'h13);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'h01);
		pinMv[3] <= 2000;
		pinMv[5] <= 1000;
		for (int i = 0; i < 5; i++) begin
			wr(3'h6, {3'h0, i < 4, i[1:0], 2'h1});
			pinMv[2] <= 1500;
			settle();
			wr(3'h7, 8'h07);
			nWin = 0;
			nEdge1 = 0;
			foreach (path[j]) begin
				pinMv[2] <= path[j];
				settle();
			end
			`CHECK(nWin, exp[i])
			`CHECK(irqReq[2], exp[i] != 0)
			`CHECK(nEdge1, 7)
			`CHECK(irqReq[1], 1'b0)
		end
		rdv(3'h7);
		`CHECK(rd[7:6], 2'h2)
		// level on for the second unit: its standing flag now requests
		wr(3'h1, 8'h11);
		`CHECK(irqReq[1], 1'b1)
		wr(3'h0, 8'h00);
		pinMv[2] <= 2500;
		settle();
		rdv(3'h7);
		`CHECK(rd[5:4], 2'h2)
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h17);
		wr(3'h5, 8'h3F);
		wr(3'h1, 8'h01);
		settle();
		rdv(3'h7);
		`CHECK(rd[5], 1'b0)
		wr(3'h5, 8'h1F);
		settle();
		rdv(3'h7);
		`CHECK(rd[5], 1'b1)
	endtask : t_window

	// reset, then the scenarios in turn
	initial begin
		busReq = '0;
		resetn = 1'b0;
		pinMv = '{default: 0};
		numErrors = 0;
		nCompared = 0;
		nEdge = 0;
		nWin = 0;
		nEdge1 = 0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_settings();
		t_edges();
		t_window();
		finish_test();
	end
endmodule : cmpev_top_test
